//--- gpwx_pads.sv
`timescale 1ns/100ps
`default_nettype none
module gpwx_pads
  import gpwx_pkg::*;
(
  input wire logic i_clk,
  input wire logic [GPWX_PINS-1:0] i_drv,
  input wire logic [GPWX_PINS-1:0] i_oe_n,
  input wire logic [GPWX_PINS-1:0] i_pu,
  input wire logic [GPWX_PINS-1:0] i_ext,
  input wire logic [GPWX_PINS-1:0] i_ext_en,
  input wire logic [GPWX_PINS-1:0] i_pd,
  output logic [GPWX_PINS-1:0] o_pad
);
  logic tog_q = 1'b0;
  // an undriven pad wanders so a stale value is never read as valid
  always @(posedge i_clk) tog_q <= !tog_q;
  always_comb
  begin
    for (int i = 0; i < GPWX_PINS; i++)
    begin
      if (!i_oe_n[i])
        o_pad[i] = i_drv[i];
      else if (i_ext_en[i])
        o_pad[i] = i_ext[i];
      else if (i_pu[i] || i_pd[i])
        o_pad[i] = i_pu[i];
      else
        o_pad[i] = tog_q;
    end
  end
endmodule : gpwx_pads
`default_nettype wire

//--- gpwx_pkg.sv
package gpwx_pkg;
  localparam int GPWX_PORTS = 3;
  localparam int GPWX_PINS = 24;
  localparam logic [3:0] GPWX_CFG_ANALOG = 4'h0;
  localparam logic [3:0] GPWX_CFG_IN_FLOAT = 4'h4;
  localparam logic [3:0] GPWX_CFG_IN_PULL = 4'h8;
  localparam logic [3:0] GPWX_CFG_OUT_PP = 4'h1;
  localparam logic [3:0] GPWX_CFG_OUT_OD = 4'h5;
  localparam logic [3:0] GPWX_CFG_ALT_PP = 4'h9;
  localparam logic [3:0] GPWX_CFG_ALT_SCLK = 4'hb;
  localparam logic [3:0] GPWX_CFG_ALT_OD = 4'hd;
  localparam logic [3:0] GPWX_CFG_RESET = 4'h4;
  localparam logic [2:0] GPWX_TRIG_OFF = 3'h0;
  localparam logic [2:0] GPWX_TRIG_RISE = 3'h1;
  localparam logic [2:0] GPWX_TRIG_FALL = 3'h2;
  localparam logic [2:0] GPWX_TRIG_BOTH = 3'h3;
  localparam logic [2:0] GPWX_TRIG_HIGH = 3'h4;
  localparam logic [2:0] GPWX_TRIG_LOW = 3'h5;
  localparam int GPWX_CLK_MHZ = 200;
  localparam int GPWX_UNFILT_NS = 80;
  localparam int GPWX_FILT_NS = 450;
  // pulse widths as cycle counts; least times round up
  localparam int GPWX_UNFILT_CYC = (GPWX_UNFILT_NS * GPWX_CLK_MHZ + 999) / 1000;
  localparam int GPWX_FILT_CYC = (GPWX_FILT_NS * GPWX_CLK_MHZ + 999) / 1000;
  localparam int GPWX_WAKE_SAMPLES = 3;
  localparam int GPWX_SEL_PORT_B = 8;
  localparam int GPWX_SEL_PORT_C = 16;
  localparam int GPWX_SEL_LAST = 23;
  localparam int GPWX_PIN_INT_A = 8;
  localparam int GPWX_PIN_INT_B = 14;
endpackage : gpwx_pkg

//--- gpwx_properties.sv
`timescale 1ns/100ps
`default_nettype none
module gpwx_properties
  import gpwx_pkg::*;
#(
  parameter int NPINS = GPWX_PINS
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [NPINS-1:0] o_pin,
  input wire logic [NPINS-1:0] o_pin_oe_n,
  input wire logic [NPINS-1:0] o_pull_up,
  input wire logic [NPINS-1:0] o_pull_down,
  input wire logic [NPINS-1:0] i_alt_out,
  input wire logic [NPINS-1:0] i_alt_present,
  input wire logic [4*NPINS-1:0] i_pin_mode_config,
  input wire logic i_output_latch_we,
  input wire logic i_output_set_we,
  input wire logic i_output_clear_we,
  input wire logic [NPINS-1:0] i_output_mask,
  input wire logic [NPINS-1:0] o_output_latch_reg,
  input wire logic [NPINS-1:0] o_pin_input_reg,
  input wire logic i_two_wire_debug,
  input wire logic i_debug_forced,
  input wire logic [2:0] o_debug_status_reg
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // four cycles covers the pad sync path as well as drive latency
  sequence held(int p, logic [3:0] m);
    (i_pin_mode_config[4*p+:4] == m && !i_rst)[*4];
  endsequence
  property alt_drv(logic [3:0] m);
    held(2, m) |-> !o_pin_oe_n[2] &&
      o_pin[2] == $past(i_alt_out[2] && i_alt_present[2]);
  endproperty
  set_bits_a: assert property (
    i_output_set_we && !i_output_latch_we && !i_output_clear_we |=>
    o_output_latch_reg == ($past(o_output_latch_reg) | $past(i_output_mask)))
    else $error("latch set wrong");
  analog_pin_a: assert property (
    held(0, 4'h0) |-> o_pin_input_reg[0] && o_pin_oe_n[0] &&
    !o_pull_up[0] && !o_pull_down[0]) else $error("analog pin wrong");
  pull_select_a: assert property (
    held(0, 4'h8) |-> o_pin_oe_n[0] &&
    o_pull_up[0] == $past(o_output_latch_reg[0]) &&
    o_pull_down[0] == !$past(o_output_latch_reg[0]))
    else $error("pull select wrong");
  push_pull_a: assert property (
    held(0, 4'h1) |-> !o_pin_oe_n[0] && !o_pull_up[0] && !o_pull_down[0] &&
    o_pin[0] == $past(o_output_latch_reg[0])) else $error("push-pull wrong");
  open_drain_a: assert property (
    held(1, 4'h5) |-> o_pin_oe_n[1] == $past(o_output_latch_reg[1]) &&
    (o_pin_oe_n[1] || !o_pin[1]) && !o_pull_up[1] && !o_pull_down[1])
    else $error("open drain wrong");
  alt_drive_a: assert property (alt_drv(4'h9))
    else $error("alternate drive wrong");
  sclk_drive_a: assert property (alt_drv(4'hb))
    else $error("spi clock drive wrong");
  debug_status_a: assert property (
    o_debug_status_reg[1:0] == {i_two_wire_debug, i_debug_forced})
    else $error("debug status wrong");
endmodule : gpwx_properties
`default_nettype wire

//--- gpwx_top.sv
`timescale 1ns/100ps
`default_nettype none
module gpwx_top
  import gpwx_pkg::*;
#(
  parameter int NPINS = GPWX_PINS
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [NPINS-1:0] i_pin,
  output logic [NPINS-1:0] o_pin,
  output logic [NPINS-1:0] o_pin_oe_n,
  output logic [NPINS-1:0] o_pull_up,
  output logic [NPINS-1:0] o_pull_down,
  output logic [NPINS-1:0] o_periph_in,
  input wire logic [NPINS-1:0] i_alt_out,
  input wire logic [NPINS-1:0] i_alt_present,
  input wire logic [4*NPINS-1:0] i_pin_mode_config,
  input wire logic i_output_latch_we,
  input wire logic [NPINS-1:0] i_output_latch_wdata,
  input wire logic i_output_set_we,
  input wire logic i_output_clear_we,
  input wire logic [NPINS-1:0] i_output_mask,
  output logic [NPINS-1:0] o_output_latch_reg,
  output logic [NPINS-1:0] o_pin_input_reg,
  input wire logic [NPINS-1:0] i_wake_enable_reg,
  input wire logic [NPINS-1:0] i_wake_filter_enable,
  input wire logic i_wake_sel_gpio,
  input wire logic i_sleep,
  input wire logic i_slow_osc,
  output logic o_wake_event,
  output logic o_wake_by_pins,
  input wire logic i_wake_flag_clear,
  input wire logic [11:0] i_ext_int_trigger_mode,
  input wire logic [3:0] i_ext_int_filter_enable,
  input wire logic [4:0] i_ext_int_c_pin_select,
  input wire logic [4:0] i_ext_int_d_pin_select,
  input wire logic [3:0] i_ext_int_flag_clear,
  output logic [3:0] o_ext_int_pending_flags,
  input wire logic i_debug_forced,
  input wire logic i_two_wire_debug,
  input wire logic i_boot_select_n,
  input wire logic i_boot_sample,
  output logic [2:0] o_debug_status_reg
);
  localparam logic [7:0] UNF_CYC = 8'(GPWX_UNFILT_CYC);
  localparam logic [7:0] FLT_CYC = 8'(GPWX_FILT_CYC);

  function automatic logic [3:0] mode_of(input logic [4*NPINS-1:0] cfg,
    input int idx);
    mode_of = cfg[4*idx +: 4];
  endfunction : mode_of

  function automatic logic is_analog(input logic [3:0] m);
    is_analog = (m == GPWX_CFG_ANALOG);
  endfunction : is_analog

  function automatic logic pin_by_sel(input logic [NPINS-1:0] lvl,
    input logic [4:0] sel);
    // selects beyond the last pin read as idle high
    if (int'(sel) > GPWX_SEL_LAST)
      pin_by_sel = 1'b1;
    else
      pin_by_sel = lvl[sel];
  endfunction : pin_by_sel

  logic [NPINS-1:0] sy0_q, sy1_q;
  logic [NPINS-1:0] lvl;
  logic [NPINS-1:0] latch_q, latch_d;
  logic [NPINS-1:0] pin_q, pin_d, oen_q, oen_d;
  logic [NPINS-1:0] pu_q, pu_d, pd_q, pd_d;
  logic [NPINS-1:0] inreg_q;

  // two flops on the pads before any logic looks at them
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sy0_q <= '1;
      sy1_q <= '1;
    end
    else if (i_ce)
    begin
      sy0_q <= i_pin;
      sy1_q <= sy0_q;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      // analog pins see a forced high digital input
      assign lvl[g] = is_analog(mode_of(i_pin_mode_config, g)) ? 1'b1
        : sy1_q[g];
    end
  endgenerate

  always_comb
  begin
    latch_d = latch_q;
    if (i_output_latch_we)
      latch_d = i_output_latch_wdata;
    if (i_output_set_we)
      latch_d = latch_d | i_output_mask;
    if (i_output_clear_we)
      latch_d = latch_d & ~i_output_mask;
    pin_d = '0;
    oen_d = '1;
    pu_d = '0;
    pd_d = '0;
    for (int i = 0; i < NPINS; i++)
    begin
      case (mode_of(i_pin_mode_config, i))
        GPWX_CFG_ANALOG: ;
        GPWX_CFG_IN_FLOAT: ;
        GPWX_CFG_IN_PULL:
        begin
          pu_d[i] = latch_q[i];
          pd_d[i] = ~latch_q[i];
        end
        GPWX_CFG_OUT_PP:
        begin
          pin_d[i] = latch_q[i];
          oen_d[i] = 1'b0;
        end
        GPWX_CFG_OUT_OD:
          oen_d[i] = latch_q[i];
        GPWX_CFG_ALT_PP, GPWX_CFG_ALT_SCLK:
        begin
          pin_d[i] = i_alt_present[i] & i_alt_out[i];
          oen_d[i] = 1'b0;
        end
        GPWX_CFG_ALT_OD:
          oen_d[i] = i_alt_present[i] & i_alt_out[i];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      latch_q <= '0;
      pin_q <= '0;
      oen_q <= '1;
      pu_q <= '0;
      pd_q <= '0;
      inreg_q <= '0;
    end
    else if (i_ce)
    begin
      latch_q <= latch_d;
      pin_q <= pin_d;
      oen_q <= oen_d;
      pu_q <= pu_d;
      pd_q <= pd_d;
      inreg_q <= lvl;
    end
  end

  assign o_pin = pin_q;
  assign o_pin_oe_n = oen_q;
  assign o_pull_up = pu_q;
  assign o_pull_down = pd_q;
  assign o_output_latch_reg = latch_q;
  assign o_pin_input_reg = inreg_q;
  assign o_periph_in = inreg_q;

  // external interrupts
  logic [3:0] src;
  logic [3:0] prev_q, prev_d, stab_q, stab_d, flag_q, flag_d;
  logic [7:0] cnt_q [4];
  logic [7:0] cnt_d [4];
  always_comb
  begin
    src[0] = lvl[GPWX_PIN_INT_A];
    src[1] = lvl[GPWX_PIN_INT_B];
    src[2] = pin_by_sel(lvl, i_ext_int_c_pin_select);
    src[3] = pin_by_sel(lvl, i_ext_int_d_pin_select);
    prev_d = stab_q;
    stab_d = stab_q;
    flag_d = flag_q & ~i_ext_int_flag_clear;
    for (int k = 0; k < 4; k++)
    begin
      cnt_d[k] = cnt_q[k];
      // qualify: new level must persist the minimum width
      if (src[k] == stab_q[k])
        cnt_d[k] = '0;
      else if (cnt_q[k] + 8'h01 >= (i_ext_int_filter_enable[k] ? FLT_CYC
        : UNF_CYC))
      begin
        stab_d[k] = src[k];
        cnt_d[k] = '0;
      end
      else
        cnt_d[k] = cnt_q[k] + 8'h01;
      // set beats clear in the same cycle
      case (i_ext_int_trigger_mode[3*k +: 3])
        GPWX_TRIG_RISE:
          if (stab_q[k] && !prev_q[k]) flag_d[k] = 1'b1;
        GPWX_TRIG_FALL:
          if (!stab_q[k] && prev_q[k]) flag_d[k] = 1'b1;
        GPWX_TRIG_BOTH:
          if (stab_q[k] != prev_q[k]) flag_d[k] = 1'b1;
        GPWX_TRIG_HIGH:
          if (stab_q[k]) flag_d[k] = 1'b1;
        GPWX_TRIG_LOW:
          if (!stab_q[k]) flag_d[k] = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      prev_q <= '1;
      stab_q <= '1;
      flag_q <= '0;
      for (int k = 0; k < 4; k++)
        cnt_q[k] <= '0;
    end
    else if (i_ce)
    begin
      prev_q <= prev_d;
      stab_q <= stab_d;
      flag_q <= flag_d;
      for (int k = 0; k < 4; k++)
        cnt_q[k] <= cnt_d[k];
    end
  end
  assign o_ext_int_pending_flags = flag_q;

  // wake monitoring; slow oscillator sampled as a pin
  logic osc0_q, osc1_q, osc2_q;
  logic wflag_q, wflag_d;
  logic [NPINS-1:0] armed;
  gpwx_wake_if wif();
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_arm
      assign armed[g] = i_wake_enable_reg[g] & i_wake_sel_gpio
        & ~is_analog(mode_of(i_pin_mode_config, g));
    end
  endgenerate
  assign wif.level = lvl;
  assign wif.armed = armed;
  assign wif.filt = i_wake_filter_enable;
  assign wif.sleeping = i_sleep;
  assign wif.tick = osc1_q & ~osc2_q;
  gpwx_wake u_wake (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .w(wif.wake)
  );

  always_comb
  begin
    wflag_d = wflag_q & ~i_wake_flag_clear;
    if (wif.event_p)
      wflag_d = 1'b1;
  end

  // boot select caught by a clocked sample, never at reset
  logic bsy0_q, bsy1_q, boot_q, boot_d;
  always_comb
  begin
    boot_d = boot_q;
    if (i_boot_sample)
      boot_d = ~bsy1_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      osc0_q <= 1'b0;
      osc1_q <= 1'b0;
      osc2_q <= 1'b0;
      wflag_q <= 1'b0;
      bsy0_q <= 1'b1;
      bsy1_q <= 1'b1;
      boot_q <= 1'b0;
    end
    else if (i_ce)
    begin
      osc0_q <= i_slow_osc;
      osc1_q <= osc0_q;
      osc2_q <= osc1_q;
      wflag_q <= wflag_d;
      bsy0_q <= i_boot_select_n;
      bsy1_q <= bsy0_q;
      boot_q <= boot_d;
    end
  end
  assign o_wake_event = wif.event_p;
  assign o_wake_by_pins = wflag_q;
  // read-only status word: forced, two-wire, boot select
  assign o_debug_status_reg = {boot_q, i_two_wire_debug,
    i_debug_forced};
endmodule : gpwx_top
`default_nettype wire

//--- gpwx_wake.sv
`timescale 1ns/100ps
`default_nettype none
module gpwx_wake
  import gpwx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  gpwx_wake_if.wake w
);
  logic [GPWX_PINS-1:0] capt_q, capt_d;
  logic [GPWX_PINS-1:0] s0_q, s0_d, s1_q, s1_d, s2_q, s2_d;
  logic was_q, was_d;
  logic ev_q, ev_d;
  logic hit;
  always_comb
  begin
    capt_d = capt_q;
    s0_d = s0_q;
    s1_d = s1_q;
    s2_d = s2_q;
    was_d = w.sleeping;
    hit = 1'b0;
    if (w.sleeping && !was_q)
    begin
      capt_d = w.level;
      s0_d = w.level;
      s1_d = w.level;
      s2_d = w.level;
    end
    else if (w.tick)
    begin
      // slow-clock samples shifted on each oscillator tick
      s2_d = s1_q;
      s1_d = s0_q;
      s0_d = w.level;
    end
    for (int i = 0; i < GPWX_PINS; i++)
    begin
      if (w.armed[i] && w.sleeping && was_q)
      begin
        if (w.filt[i])
          hit = hit | ((s0_q[i] == s1_q[i]) && (s1_q[i] == s2_q[i])
            && (s0_q[i] != capt_q[i]));
        else
          hit = hit | (w.level[i] != capt_q[i]);
      end
    end
    ev_d = hit & ~ev_q;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      capt_q <= '0;
      s0_q <= '0;
      s1_q <= '0;
      s2_q <= '0;
      was_q <= 1'b0;
      ev_q <= 1'b0;
    end
    else if (i_ce)
    begin
      capt_q <= capt_d;
      s0_q <= s0_d;
      s1_q <= s1_d;
      s2_q <= s2_d;
      was_q <= was_d;
      ev_q <= ev_d;
    end
  end
  assign w.event_p = ev_q;
endmodule : gpwx_wake
`default_nettype wire

//--- gpwx_wake_if.sv
`timescale 1ns/100ps
`default_nettype none
interface gpwx_wake_if;
  logic [23:0] level;
  logic [23:0] armed;
  logic [23:0] filt;
  logic sleeping;
  logic tick;
  logic event_p;
  modport core(output level, output armed, output filt, output sleeping,
    output tick, input event_p);
  modport wake(input level, input armed, input filt, input sleeping,
    input tick, output event_p);
endinterface : gpwx_wake_if
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top import gpwx_pkg::*;;
  logic i_clk, i_rst, i_ce, i_output_latch_we, i_output_set_we;
  logic i_output_clear_we, i_wake_sel_gpio, i_sleep, i_slow_osc;
  logic o_wake_event, o_wake_by_pins, i_wake_flag_clear, i_debug_forced;
  logic i_two_wire_debug, i_boot_select_n, i_boot_sample;
  logic [23:0] i_pin, o_pin, o_pin_oe_n, o_pull_up, o_pull_down;
  logic [23:0] o_periph_in, i_alt_out, i_alt_present, i_output_latch_wdata;
  logic [23:0] i_output_mask, o_output_latch_reg, o_pin_input_reg;
  logic [23:0] i_wake_enable_reg, i_wake_filter_enable, ext, ext_en;
  logic [23:0] el, eo, ed, eu, edn, ei, msk;
  logic [95:0] i_pin_mode_config;
  logic [11:0] i_ext_int_trigger_mode;
  logic [3:0] i_ext_int_filter_enable, i_ext_int_flag_clear, e;
  logic [3:0] o_ext_int_pending_flags, op;
  logic [4:0] i_ext_int_c_pin_select, i_ext_int_d_pin_select;
  logic [2:0] o_debug_status_reg;
  logic [3:0] codes [8] = '{4'h0, 4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'hb, 4'hd};
  int seed = 44487, fails = 0, checks = 0, cyc = 0, wakes = 0;

  gpwx_top uut (.*);
  gpwx_pads u_pads (.i_clk(i_clk), .i_drv(o_pin), .i_oe_n(o_pin_oe_n),
    .i_pu(o_pull_up), .i_pd(o_pull_down), .i_ext(ext), .i_ext_en(ext_en),
    .o_pad(i_pin));

  always #2.5 i_clk = !i_clk;
  always #100 i_slow_osc = !i_slow_osc;
  always @(posedge i_clk)
  begin
    cyc++;
    // the wake pulse stands one cycle, so each edge sees it once
    if (o_wake_event === 1'b1)
      wakes++;
    if (cyc == 8000)
    begin
      fails++;
      conclude();
    end
  end

  function automatic logic [3:0] exp_pin(logic [3:0] m, logic l, a, p);
    case (m)
      GPWX_CFG_IN_PULL: return {2'b10, l, !l};
      GPWX_CFG_OUT_PP: return {1'b0, l, 2'b00};
      GPWX_CFG_OUT_OD: return {l, 3'b000};
      GPWX_CFG_ALT_PP, GPWX_CFG_ALT_SCLK: return {1'b0, a & p, 2'b00};
      GPWX_CFG_ALT_OD: return {a & p, 3'b000};
      default: return 4'b1000;
    endcase
  endfunction : exp_pin

  task automatic chk(string n, logic [23:0] x, logic [23:0] g);
    checks++;
    if (g !== x)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic tick(int n);
    repeat (n) @(negedge i_clk);
  endtask : tick

  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  initial
  begin
    {i_clk, i_slow_osc, i_output_latch_we, i_output_set_we, i_sleep} = '0;
    {i_output_clear_we, i_wake_sel_gpio, i_wake_flag_clear} = '0;
    {i_debug_forced, i_two_wire_debug, i_boot_sample, ext} = '0;
    {i_alt_out, i_alt_present, i_output_latch_wdata, i_output_mask} = '0;
    {i_wake_enable_reg, i_wake_filter_enable, i_ext_int_trigger_mode} = '0;
    {i_ext_int_filter_enable, i_ext_int_flag_clear} = '0;
    {i_ext_int_c_pin_select, i_ext_int_d_pin_select} = '0;
    i_pin_mode_config = {24{GPWX_CFG_RESET}};
    {i_ce, i_rst, i_boot_select_n, ext_en} = '1;
    el = '0;
    tick(6);
    i_rst = 0;
    chk("oe_n", '1, o_pin_oe_n);
    for (int n = 0; n < 30; n++)
    begin
      op = 4'($random(seed));
      i_output_latch_wdata = $random(seed);
      i_output_mask = $random(seed);
      i_output_latch_we = op[1:0] == 0;
      i_output_set_we = op[1:0] == 1;
      i_output_clear_we = op[1];
      i_debug_forced = op[2];
      i_two_wire_debug = op[3];
      el = op[1:0] == 0 ? i_output_latch_wdata : op[1:0] == 1 ?
        el | i_output_mask : el & ~i_output_mask;
      tick(1);
      {i_output_latch_we, i_output_set_we, i_output_clear_we} = '0;
      chk("latch", el, o_output_latch_reg);
      chk("dbg", 24'(op[3:2]), 24'(o_debug_status_reg[1:0]));
    end
    i_boot_select_n = 0;
    tick(4);
    i_boot_sample = 1;
    tick(1);
    i_boot_sample = 0;
    tick(2);
    chk("boot", 24'h1, 24'(o_debug_status_reg[2]));
    for (int k = 0; k < 8; k++)
    begin
      i_pin_mode_config = {24{codes[k]}};
      {i_alt_out, i_alt_present, ext, ext_en} = {$random(seed),
        $random(seed), $random(seed), $random(seed)};
      el = $random(seed);
      i_output_latch_wdata = el;
      i_output_latch_we = 1;
      tick(1);
      i_output_latch_we = 0;
      tick(6);
      for (int i = 0; i < 24; i++)
      begin
        e = exp_pin(codes[k], el[i], i_alt_out[i], i_alt_present[i]);
        {eo[i], eu[i], edn[i]} = {e[3], e[1], e[0]};
        ed[i] = e[2] & !e[3];
        ei[i] = codes[k] == 0 || (!e[3] ? e[2] : ext_en[i] ? ext[i] : e[1]);
        msk[i] = codes[k] == 0 || !e[3] || ext_en[i] || e[1] || e[0];
      end
      chk("oe_n", eo, o_pin_oe_n);
      chk("drive", ed, o_pin & ~o_pin_oe_n);
      chk("pull_up", eu, o_pull_up);
      chk("pull_down", edn, o_pull_down);
      chk("input", ei & msk, o_pin_input_reg & msk);
      chk("periph_in", ei & msk, o_periph_in & msk);
    end
    // all pads move together so every source sees the same edge
    i_pin_mode_config = {24{GPWX_CFG_IN_FLOAT}};
    ext_en = '1;
    for (int m = 0; m < 6; m++)
    begin
      i_ext_int_trigger_mode = {4{3'(m)}};
      i_ext_int_filter_enable = {4{m[0]}};
      i_ext_int_c_pin_select = 5'($unsigned($random(seed)) % 24);
      i_ext_int_d_pin_select = 5'($unsigned($random(seed)) % 24);
      ext = '0;
      tick(120);
      i_ext_int_flag_clear = '1;
      tick(1);
      i_ext_int_flag_clear = '0;
      tick(3);
      ext = '1;
      tick(120);
      chk("flags", 24'({4{m >= 4 || m % 2 == 1}}),
        24'(o_ext_int_pending_flags));
      i_ext_int_flag_clear = '1;
      tick(1);
      i_ext_int_flag_clear = '0;
      tick(3);
      chk("flags", 24'({4{m == 4}}),
        24'(o_ext_int_pending_flags));
    end
    i_wake_enable_reg = 24'h8;
    for (int p = 0; p < 3; p++)
    begin
      i_wake_sel_gpio = p != 0;
      i_wake_filter_enable = {24{p == 2}};
      ext = '0;
      tick(5);
      wakes = 0;
      i_sleep = 1;
      tick(5);
      ext[3] = 1;
      for (int t = 0; t < 400 && o_wake_by_pins !== 1'b1; t++)
        tick(1);
      chk("wake", 24'(p != 0), 24'(o_wake_by_pins));
      chk("wake_event", 24'(p != 0), 24'(wakes > 0));
      i_sleep = 0;
      i_wake_flag_clear = 1;
      tick(1);
      i_wake_flag_clear = 0;
      tick(2);
      chk("wake_clear", '0, 24'(o_wake_by_pins));
    end
    conclude();
  end
endmodule : tb_top
bind gpwx_top gpwx_properties #(.NPINS(NPINS)) u_props (.*);
`default_nettype wire
